// *** common/dssr_regs.svh ***
// Contract
// - the block holds two independent serial shift registers, each with one data input and one data output.
// - the register length is a build parameter of 16, 25, 32, 50 or 100 stages, shared by both registers.
// - the serial input is captured into the first stage while the first clock phase is active; here it is latched then and enters the first stage in phase two.
// - the serial output takes its new value on the falling edge of the second clock phase.
// - with the first phase parked at 0 and the second at 1, all stored bits are kept indefinitely.
// - a third phase is derived internally from the two external phases to keep data static.
// - data and clock pins use negative logic, the down level meaning 1 and the up level meaning 0.
`ifndef DSSR_REGS_SVH
`define DSSR_REGS_SVH
`define DSSR_LEN_DEFAULT 16
`define DSSR_FIFO_DEPTH 4
`define DSSR_CLK_NS 100
`define DSSR_PHI2_LOW_MAX_NS 10000
`define DSSR_PHI2_LOW_MAX_CYC (`DSSR_PHI2_LOW_MAX_NS / `DSSR_CLK_NS)
`endif

// *** common/dssr_pkg.sv ***
package dssr_pkg;
    // phase sequencer states of the internal cycle
    typedef enum logic [1:0] {
        DSSR_IDLE = 2'b00,
        DSSR_LOADED = 2'b01,
        DSSR_XFER = 2'b10
    } dssr_phase_t;
endpackage

// *** hw/dssr_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module dssr_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // handshakes
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/dssr_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dssr_regs.svh"
module dssr_top #(
    parameter int LEN = `DSSR_LEN_DEFAULT,
    parameter int DEPTH = `DSSR_FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // external clock phases, negative logic (pin low = 1)
    input wire logic phi1_pin,
    input wire logic phi2_pin,
    // serial data pins, negative logic
    input wire logic data_a_pin,
    input wire logic data_b_pin,
    output logic out_a_pin,
    output logic out_b_pin,
    // parallel stream of output bits {b,a}
    output logic stream_valid,
    input wire logic stream_ready,
    output logic [1:0] stream_data,
    // status
    output logic phi2_low_fault,
    output dssr_pkg::dssr_phase_t phase_state
);
    import dssr_pkg::*;

    localparam int CNT_W = $clog2(`DSSR_PHI2_LOW_MAX_CYC + 2);
    localparam bit LEN_OK = (LEN == 16) || (LEN == 25) || (LEN == 32) ||
        (LEN == 50) || (LEN == 100);

    // decoded pin levels
    logic phi1;
    logic phi2;
    logic [1:0] din;

    // phase tracking and derived strobes
    logic phi2_q;
    logic phi2_fall;
    logic phase2_only;
    logic phi3;
    logic shift;

    // storage
    logic [1:0] latch;
    logic [1:0] dout;
    logic [LEN-1:0] chain [2];
    logic [1:0] last_bits;

    // sequencer, limit monitor, buffer
    dssr_phase_t next_phase;
    logic [CNT_W-1:0] low_cnt;
    logic low_limit;
    logic fifo_in_ready;

    // unsupported lengths stop elaboration
    if (!LEN_OK) begin : g_bad_len
        $error("unsupported register length");
    end

    // phase pins, low level means active
    assign phi1 = !phi1_pin;
    assign phi2 = !phi2_pin;

    // data pins in and out
    assign din = {!data_b_pin, !data_a_pin};
    assign out_a_pin = !dout[0];
    assign out_b_pin = !dout[1];

    // phase two seen active, then inactive; phase two alone
    assign phi2_fall = phi2_q && !phi2;
    assign phase2_only = phi2 && !phi1;

    // internal third phase: transfer allowed only after a load in this cycle
    assign phi3 = (phase_state == DSSR_LOADED) && phase2_only;

    // a transfer happens only while the buffer has room
    assign shift = phi3 && fifo_in_ready;

    // last stages as they stand before a shift, for the buffer
    assign last_bits = {chain[1][LEN-1], chain[0][LEN-1]};

    // phase sequencer next state
    always_comb begin
        next_phase = phase_state;
        case (phase_state)
            // waiting for phase one
            DSSR_IDLE: begin
                if (phi1) begin
                    next_phase = DSSR_LOADED;
                end
            end

            // loaded, waiting for phase two and room
            DSSR_LOADED: begin
                if (shift) begin
                    next_phase = DSSR_XFER;
                end
            end

            // shifted, waiting for phase two to fall
            DSSR_XFER: begin
                if (phi2_fall) begin
                    next_phase = DSSR_IDLE;
                end
            end

            default: begin
                next_phase = DSSR_IDLE;
            end
        endcase
    end

    // phase sequencer state
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_state <= DSSR_IDLE;
        end else begin
            phase_state <= next_phase;
        end
    end

    // phase two at the previous edge, for its falling edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phi2_q <= 1'b0;
        end else begin
            phi2_q <= phi2;
        end
    end

    // input latch follows data while phase one is active, holds otherwise
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch <= 2'h0;
        end else if (phi1) begin
            latch <= din;
        end
    end

    // two independent chains; one shift per full phase cycle
    for (genvar g = 0; g < 2; g++) begin : g_chain
        // shift toward the output on the third phase when the buffer has room, hold otherwise
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                chain[g] <= '0;
            end else if (shift) begin
                chain[g] <= {chain[g][LEN-2:0], latch[g]};
            end
        end

        // output stage updates on phase two falling edge
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                dout[g] <= 1'b0;
            end else if (phi2_fall && phase_state == DSSR_XFER) begin
                dout[g] <= chain[g][LEN-1];
            end
        end
    end

    // limit reached once the count stands at the maximum
    assign low_limit = (low_cnt >= CNT_W'(`DSSR_PHI2_LOW_MAX_CYC));

    // cycles with phase two held at 0 (pin high), saturating
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= '0;
        end else if (phi2) begin
            low_cnt <= '0;
        end else if (low_cnt <= CNT_W'(`DSSR_PHI2_LOW_MAX_CYC)) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // sticky fault once phase two stays at 0 past its limit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phi2_low_fault <= 1'b0;
        end else if (!phi2 && low_limit) begin
            phi2_low_fault <= 1'b1;
        end
    end

    // output bit stream buffer, stalls the shift when full
    dssr_fifo #(
        .WIDTH(2),
        .DEPTH(DEPTH)
    ) u_fifo (
        // clock and reset
        .mclk(mclk),
        .rst_n(rst_n),
        // fill side from the last stages
        .in_valid(phi3),
        .in_ready(fifo_in_ready),
        .in_data(last_bits),
        // drain side to the stream port
        .out_valid(stream_valid),
        .out_ready(stream_ready),
        .out_data(stream_data)
    );
endmodule
`default_nettype wire

// *** verif/dssr_clkdrv.sv ***
`timescale 1ns/1ps
`default_nettype none
module dssr_clkdrv (
    // clock
    input wire logic mclk,
    // pins, low means 1
    output logic phi1_pin,
    output logic phi2_pin,
    output logic data_a_pin,
    output logic data_b_pin
);
    // parked phases, data idle
    initial {phi1_pin, phi2_pin, data_b_pin, data_a_pin} = 4'h9;
    // one phase cycle, phase two at 0 for w cycles
    task automatic cycle(input logic [1:0] d, input int w);
        @(negedge mclk);
        phi1_pin = 1'h0;
        {data_b_pin, data_a_pin} = ~d;
        @(negedge mclk);
        phi1_pin = 1'h1;
        {data_b_pin, data_a_pin} = d; // released lines flip
        @(negedge mclk);
        phi2_pin = 1'h1;
        repeat (w) @(negedge mclk);
        phi2_pin = 1'h0;
    endtask
    // bare phase two pulse, closes a shift that was held back
    task automatic fall(input int w);
        @(negedge mclk);
        phi2_pin = 1'h1;
        repeat (w) @(negedge mclk);
        phi2_pin = 1'h0;
    endtask
endmodule
`default_nettype wire

// *** verif/dssr_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dssr_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // pins and state
    input wire logic phi1_pin,
    input wire logic phi2_pin,
    input wire logic out_a_pin,
    input wire logic out_b_pin,
    input var dssr_pkg::dssr_phase_t phase_state
);
    import dssr_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // shorthand for parked phases and states
    wire park = phi1_pin & ~phi2_pin;
    wire ld = phase_state == DSSR_LOADED;
    wire xf = phase_state == DSSR_XFER;
    wire idle = phase_state == DSSR_IDLE;
    wire [1:0] q = {out_b_pin, out_a_pin};
    // phase two going from 1 to 0
    sequence s_fall;
        !phi2_pin ##1 phi2_pin;
    endsequence
    a_phi1_load: assert property (!phi1_pin |=> ld) else $error("load");
    a_shift_cause: assert property ($rose(xf) |-> $past(park)) else $error("shift");
    a_fall_idle: assert property (s_fall ##0 xf |=> idle) else $error("idle");
    a_out_fall: assert property ($changed(q) |-> $past(phi2_pin) && !$past(phi2_pin, 2))
        else $error("out");
    a_park_hold: assert property (park && $past(park) |-> $stable(q)) else $error("hold");
    a_idle_stay: assert property (idle && phi1_pin |=> idle) else $error("stray");
    a_xfer_wait: assert property (xf && park |=> xf) else $error("wait");
    a_load_wait: assert property (ld && phi1_pin && phi2_pin |=> ld) else $error("stall");
endmodule
bind dssr_top dssr_monitor mon_u (.mclk, .rst_n, .phi1_pin, .phi2_pin,
    .out_a_pin, .out_b_pin, .phase_state);
`default_nettype wire

// *** verif/test_dual_static_shift_register.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_dual_static_shift_register;
    import dssr_pkg::*;
    localparam logic [31:0] PA = 32'h3a5c_96e1;
    logic mclk = 1'h0, rst_n = 1'h0, stream_ready = 1'h1;
    logic phi1_pin, phi2_pin, data_a_pin, data_b_pin, out_a_pin, out_b_pin;
    logic stream_valid, phi2_low_fault;
    logic [1:0] stream_data;
    dssr_phase_t phase_state;
    int errors = 0, compares = 0;
    // clock, far side, block
    always #50 mclk = ~mclk;
    dssr_clkdrv mdl_u (.mclk, .phi1_pin, .phi2_pin, .data_a_pin, .data_b_pin);
    dssr_top dut_u (.mclk, .rst_n, .phi1_pin, .phi2_pin, .data_a_pin, .data_b_pin,
        .out_a_pin, .out_b_pin, .stream_valid, .stream_ready, .stream_data,
        .phi2_low_fault, .phase_state);
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %h %h", $time, seen, exp);
        end
    endtask
    // counts and verdict
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // bits leave inverted after 16 cycles, phase two short and long
    task automatic t_shift();
        logic [1:0] e;
        for (int k = 1; k < 25; k++) begin
            mdl_u.cycle({PA[k + 5], PA[k]}, 1 + k % 3);
            e = k < 16 ? 2'h3 : ~{PA[k - 10], PA[k - 15]};
            check({out_b_pin, out_a_pin}, e);
        end
        $display("shift done");
    endtask
    // full buffer stalls the shift until one entry drains, a bare phase two ends it
    task automatic t_stall();
        int n = 0;
        stream_ready = 1'h0;
        repeat (5) mdl_u.cycle(2'h1, 1);
        check(phase_state, DSSR_LOADED);
        check(stream_data, {PA[14], PA[9]});
        stream_ready = 1'h1;
        repeat (20) begin
            n += stream_valid;
            @(negedge mclk);
        end
        check(8'(n), 8'h05);
        mdl_u.fall(1);
        check(phase_state, DSSR_IDLE);
        check({out_b_pin, out_a_pin}, {!PA[19], !PA[14]});
        $display("stall done");
    endtask
    // phase two at 0 too long, then reset again
    task automatic t_fault();
        mdl_u.cycle(2'h0, 120);
        check(phi2_low_fault, 1'h1);
        rst_n = 1'h0;
        repeat (20) @(negedge mclk);
        rst_n = 1'h1;
        check({phi2_low_fault, out_b_pin, out_a_pin}, 8'h03);
        $display("fault done");
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge mclk);
        rst_n = 1'h1;
        t_shift();
        t_stall();
        t_fault();
        stop_test();
    end
endmodule
`default_nettype wire
